// file: shared/dps_cfg.svh
// Offsets, field positions, reset values and timing counts of the speed-program block.
// Assumes a 200 MHz system clock and a byte-addressed Avalon-MM register window.
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH
`define DPS_CLK_MHZ 200
`define DPS_TICK_MS 100
`define DPS_DEB_NS 1000
`define DPS_DEB_CYC (((`DPS_DEB_NS) * `DPS_CLK_MHZ + 999) / 1000)
`define DPS_FS_NS 1000
`define DPS_FS_CYC (((`DPS_FS_NS) * `DPS_CLK_MHZ) / 1000)
`define DPS_TICK_CYC (`DPS_TICK_MS * 1000 * `DPS_CLK_MHZ)
`define DPS_A_CTRL 6'h00
`define DPS_A_GAIN 6'h01
`define DPS_A_FILT 6'h02
`define DPS_A_ICNT 6'h03
`define DPS_A_SDIR 6'h04
`define DPS_A_SRAMP 6'h05
`define DPS_A_MAIN 6'h06
`define DPS_A_PRE 6'h07
`define DPS_A_TMR 6'h0E
`define DPS_A_STAT 6'h16
`define DPS_A_CNT 6'h17
`define DPS_F_NBR 0
`define DPS_F_RET 1
`define DPS_F_RES 2
`define DPS_F_PAT 3
`define DPS_F_CYC 6
`define DPS_F_SRC 8
`define DPS_PAT_NORM 3'h0
`define DPS_PAT_EXT4 3'h1
`define DPS_PAT_EXT8 3'h2
`define DPS_PAT_TRAV 3'h3
`define DPS_PAT_INT 3'h4
`define DPS_PAT_DRAW 3'h5
`define DPS_GAIN_MAX 10'h3E8
`define DPS_FILT_MAX 6'h32
`define DPS_FILT_RST 6'h14
`define DPS_ICNT_MAX 16'hFFDC
`define DPS_UD_COARSE 17'h0000A
`define DPS_UD_FINE 17'h00001
`define DPS_FSHIFT 4
`define DPS_PRE_RST {16'h05DC, 16'h07D0, 16'h09C4, 16'h0BB8, 16'h0DAC, 16'h0FA0, 16'h0032}
`define DPS_TMR_RST {16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
`endif

// file: shared/dps_pkg.sv
// Types shared by the speed-program block.
// Assumes constants come from dps_cfg.svh.
`default_nettype none
package dps_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_DRAW, ST_HOLD} dps_state_e;
    typedef logic [15:0] dps_freq_t;
endpackage
`default_nettype wire

// file: logic/dps_core.sv
// Frequency reference selection and speed-program sequencer with Avalon-MM registers.
// Assumes all control pins are asynchronous and the analog word changes slowly.
// Overview of operation
// [R1] Positive analog bias means forward, negative bias means reverse.
// [R2] Negative-bias reverse is blocked unless its enable bit is set.
// [R3] Meter output is frequency scaled by 0.0 to 100.0 percent gain.
// [R4] Up/down offset is cleared at restart unless retention is set.
// [R5] Stored main setpoint survives stop and restart.
// [R6] Up/down step is 0.1 Hz or 0.01 Hz by resolution bit.
// [R7] Analog filter constant 0 to 50, default 20, larger is slower.
// [R8] Intermediate-count output is high while count reaches threshold.
// [R9] Run pattern accepts 0 to 5, default 0.
// [R10] Three select inputs form a code: 0 main, 1 to 7 presets 2 to 8.
// [R11] Eight-speed selection acts only in pattern 2.
// [R12] Main frequency comes from potentiometer when source bit is 1.
// [R13] External patterns take ramp and direction from terminals.
// [R14] Traverse running ignores all but stop, fault and emergency stop.
// [R15] Traverse uses main, preset 2, skip preset 8, timers 1 and 2.
// [R16] Internal pattern runs eight timed steps, zero timer skips a step.
// [R17] Internal steps take ramp and direction from the step words.
// [R18] Step ramp word has two bits per step, step 1 lowest.
// [R19] Drawing starts only on the external trigger terminal.
// [R20] Finished drawing holds preset 3 with done output until stop.
// [R21] Cycle mode 0 to 3: single, continuous, and each with step stops.
// [R22] Cycle mode matters only in the internal pattern.
// [R23] Single-cycle mode stops after one cycle until a new run command.
// [R24] Select and trigger inputs are synchronised and debounced.
`include "dps_cfg.svh"
`default_nettype none
module dps_core #(
    parameter int TICK_CYC = `DPS_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic run_in,
    input wire logic stop_in,
    input wire logic fault_in,
    input wire logic estop_in,
    input wire logic fwd_rev_in,
    input wire logic up_in,
    input wire logic down_in,
    input wire logic trig_in,
    input wire logic count_in,
    input wire logic count_clr_in,
    input wire logic [2:0] speed_sel_in,
    input wire logic [1:0] ramp_sel_in,
    input wire logic [15:0] analog_in,
    output dps_pkg::dps_freq_t freq_cmd_q,
    output logic dir_rev_q,
    output logic [1:0] ramp_set_q,
    output logic running_q,
    output logic draw_done_q,
    output logic count_mid_q,
    output logic [15:0] meter_output_q
);
    import dps_pkg::*;

    function automatic logic [15:0] sat16(input logic signed [17:0] v);
        sat16 = v < 0 ? 16'h0000 : (v > 18'sh0FFFF ? 16'hFFFF : v[15:0]);
    endfunction

    // Returns {wrapped, index} of the next step with a non-zero timer
    function automatic logic [3:0] nxt(input logic [7:0] nz, input logic [2:0] cur);
        logic [2:0] j;
        nxt = {1'b1, cur};
        for (int i = 7; i >= 1; i--) begin
            j = cur + 3'(i);
            if (nz[j]) begin
                nxt = {j <= cur, j};
            end
        end
    endfunction

    // Registers
    logic [8:0] ctrl_q;
    logic [9:0] gain_q;
    logic [5:0] filt_c_q;
    logic [15:0] thr_q, main_set_q, sramp_q, cnt_q;
    logic [7:0] sdir_q;
    logic [15:0] pre_q [0:6];
    logic [15:0] tmr_q [0:7];

    // Pin synchronisers
    logic [13:0] s1_q, s2_q, prev_q;
    logic [15:0] a1_q, a2_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            a1_q <= '0;
            a2_q <= '0;
        end else begin
            s1_q <= {run_in, stop_in, fault_in, estop_in, fwd_rev_in, up_in, down_in,
                     count_in, count_clr_in, ramp_sel_in, speed_sel_in};
            s2_q <= s1_q;
            a1_q <= analog_in;
            a2_q <= a1_q;
        end
    end

    // Select and trigger must sit still before they are taken, so one edge switches speed
    logic [3:0] deb_q;
    logic [7:0] deb_cnt_q;
    logic trig_s1_q, trig_s2_q;
    wire [3:0] deb_raw = {trig_s2_q, s2_q[2:0]};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            deb_q <= '0;
            deb_cnt_q <= '0;
            prev_q <= '0;
        end else begin
            trig_s1_q <= trig_in;
            trig_s2_q <= trig_s1_q;
            prev_q <= {s2_q[13:4], deb_q};
            if (deb_raw == deb_q) begin
                deb_cnt_q <= '0;
            end else if (deb_cnt_q == 8'(`DPS_DEB_CYC - 1)) begin
                deb_q <= deb_raw; // R24
                deb_cnt_q <= '0;
            end else begin
                deb_cnt_q <= deb_cnt_q + 8'h01;
            end
        end
    end

    wire s_run = s2_q[13];
    wire stop_any = s2_q[12] | s2_q[11] | s2_q[10];
    wire s_fwd_rev = s2_q[9];
    wire run_edge = s_run & ~prev_q[13];
    wire up_edge = s2_q[8] & ~prev_q[8];
    wire dn_edge = s2_q[7] & ~prev_q[7];
    wire cnt_edge = s2_q[6] & ~prev_q[6];
    wire s_cnt_clr = s2_q[5];
    wire [1:0] s_ramp = s2_q[4:3];
    wire trig_edge = deb_q[3] & ~prev_q[3];
    wire [2:0] sel = deb_q[2:0];

    wire nbr = ctrl_q[`DPS_F_NBR];
    wire retain = ctrl_q[`DPS_F_RET];
    wire res = ctrl_q[`DPS_F_RES];
    wire [2:0] pat = ctrl_q[`DPS_F_PAT +: 3];
    wire [1:0] cyc = ctrl_q[`DPS_F_CYC +: 2];
    wire src = ctrl_q[`DPS_F_SRC];

    // Timebase restarts with each run so the first step gets its full time
    dps_state_e st_q;
    wire run_start = st_q == ST_IDLE && run_edge && !stop_any;
    logic [31:0] tick_cnt_q;
    logic [7:0] fs_q;
    logic [5:0] fdiv_q;
    logic signed [15:0] filt_q;
    wire tick = tick_cnt_q == 32'(TICK_CYC - 1);
    wire fs = fs_q == 8'(`DPS_FS_CYC - 1);
    wire signed [16:0] fdiff = $signed({a2_q[15], a2_q}) - $signed({filt_q[15], filt_q});
    wire signed [16:0] fstep = fdiff >>> `DPS_FSHIFT;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= '0;
            fs_q <= '0;
            fdiv_q <= '0;
            filt_q <= '0;
        end else begin
            tick_cnt_q <= (tick || run_start) ? 32'h0 : tick_cnt_q + 32'h1;
            fs_q <= fs ? 8'h00 : fs_q + 8'h01;
            if (fs) begin
                fdiv_q <= fdiv_q >= filt_c_q ? 6'h00 : fdiv_q + 6'h01;
                if (fdiv_q >= filt_c_q) begin
                    filt_q <= filt_q + fstep[15:0]; // R7
                end
            end
        end
    end

    // Analog command: sign is the requested direction, negative dropped unless enabled
    wire an_rev = filt_q[15]; // R1
    wire an_ok = ~an_rev | nbr; // R2
    wire [15:0] amag = an_rev ? 16'(-filt_q) : filt_q;
    wire [15:0] afreq = an_ok ? amag : 16'h0000;
    wire [15:0] main_f = src ? afreq : main_set_q; // R12

    // Sequencer
    logic [2:0] step_q;
    logic [15:0] tcnt_q;
    logic phase_q;
    logic signed [16:0] ud_q;
    wire [7:0] nz;
    for (genvar g = 0; g < 8; g++) begin : g_nz
        assign nz[g] = tmr_q[g] != 16'h0000;
    end
    wire [3:0] nx = nxt(nz, step_q); // R16
    wire [3:0] first = nxt(nz, 3'h7);
    wire [15:0] tcur = tmr_q[step_q];
    wire [15:0] tphase = tmr_q[{2'b00, phase_q}]; // R15
    wire int_dir = sdir_q[step_q];
    wire [2:0] ext_idx = pat == `DPS_PAT_EXT8 ? sel : {1'b0, sel[1:0]}; // R11
    wire [15:0] ext_f = ext_idx == 3'h0 ? main_f : pre_q[ext_idx - 3'h1]; // R10
    wire [15:0] int_f = step_q == 3'h0 ? main_f : pre_q[step_q - 3'h1];
    wire [15:0] trv_base = phase_q ? pre_q[0] : main_f;
    // Skip jump at each inflection lasts one tick
    wire [15:0] trv_f = tcnt_q == 16'h0 ? sat16(18'(trv_base) - 18'(pre_q[6])) : trv_base;
    wire [15:0] norm_f = sat16(18'(main_f) + 18'(ud_q));
    wire is_norm = pat == `DPS_PAT_NORM;
    wire end_stop = nx[3] & ~cyc[0]; // R23
    wire [16:0] ud_step = res ? `DPS_UD_FINE : `DPS_UD_COARSE; // R6

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            step_q <= '0;
            tcnt_q <= '0;
            phase_q <= 1'b0;
            ud_q <= '0;
        end else begin
            if (st_q == ST_RUN && is_norm) begin
                if (up_edge) begin
                    ud_q <= ud_q + ud_step;
                end else if (dn_edge) begin
                    ud_q <= ud_q - ud_step;
                end
            end
            if (stop_any && st_q != ST_IDLE) begin
                st_q <= ST_IDLE; // R14
            end else begin
                unique case (st_q)
                    ST_IDLE: begin
                        if (run_edge && !stop_any) begin
                            tcnt_q <= '0;
                            phase_q <= 1'b0;
                            step_q <= first[2:0];
                            if (!retain) begin
                                ud_q <= '0; // R4
                            end
                            if (pat != `DPS_PAT_INT || nz != 8'h00) begin
                                st_q <= ST_RUN;
                            end
                        end
                    end
                    ST_RUN: begin
                        if (pat == `DPS_PAT_DRAW && trig_edge) begin
                            st_q <= ST_DRAW; // R19
                            tcnt_q <= '0;
                        end else if (tick && pat == `DPS_PAT_INT) begin
                            if (tcnt_q + 16'h1 >= tcur) begin
                                tcnt_q <= '0;
                                step_q <= nx[2:0];
                                if (end_stop) begin
                                    st_q <= ST_IDLE; // R21
                                end else if (cyc[1]) begin
                                    st_q <= ST_PAUSE; // R22
                                end
                            end else begin
                                tcnt_q <= tcnt_q + 16'h1;
                            end
                        end else if (tick && pat == `DPS_PAT_TRAV) begin
                            if (tcnt_q + 16'h1 >= tphase) begin
                                tcnt_q <= '0;
                                phase_q <= ~phase_q; // R15
                            end else begin
                                tcnt_q <= tcnt_q + 16'h1;
                            end
                        end
                    end
                    ST_PAUSE: begin
                        if (tick) begin
                            st_q <= ST_RUN;
                        end
                    end
                    ST_DRAW: begin
                        if (tick) begin
                            tcnt_q <= tcnt_q + 16'h1;
                            if (tcnt_q + 16'h1 >= tmr_q[0]) begin
                                st_q <= ST_HOLD;
                            end
                        end
                    end
                    ST_HOLD: begin
                    end
                endcase
            end
        end
    end

    // Output selection
    dps_freq_t f_d;
    logic dir_d;
    logic [1:0] ramp_d;
    always_comb begin
        f_d = 16'h0000;
        dir_d = s_fwd_rev; // R13
        ramp_d = s_ramp;
        unique case (st_q)
            ST_IDLE, ST_PAUSE: f_d = 16'h0000;
            ST_DRAW: f_d = main_f;
            ST_HOLD: f_d = pre_q[1]; // R20
            ST_RUN: begin
                unique case (pat)
                    `DPS_PAT_NORM: begin
                        f_d = norm_f;
                        dir_d = src ? an_rev & an_ok : s_fwd_rev; // R1
                    end
                    `DPS_PAT_EXT4, `DPS_PAT_EXT8: f_d = ext_f;
                    `DPS_PAT_TRAV: begin
                        f_d = trv_f;
                        dir_d = 1'b0; // R14
                        ramp_d = 2'h0;
                    end
                    `DPS_PAT_INT: begin
                        f_d = int_f;
                        dir_d = int_dir; // R17
                        ramp_d = sramp_q[{step_q, 1'b0} +: 2]; // R18
                    end
                    default: f_d = main_f;
                endcase
            end
        endcase
    end

    wire [25:0] mprod = freq_cmd_q * gain_q;
    wire [25:0] mscaled = mprod / 26'(`DPS_GAIN_MAX);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_cmd_q <= '0;
            dir_rev_q <= 1'b0;
            ramp_set_q <= '0;
            running_q <= 1'b0;
            draw_done_q <= 1'b0;
            count_mid_q <= 1'b0;
            meter_output_q <= '0;
            cnt_q <= '0;
        end else begin
            freq_cmd_q <= f_d;
            dir_rev_q <= dir_d;
            ramp_set_q <= ramp_d;
            running_q <= st_q != ST_IDLE;
            draw_done_q <= st_q == ST_HOLD; // R20
            meter_output_q <= mscaled[15:0]; // R3
            count_mid_q <= cnt_q >= thr_q; // R8
            if (s_cnt_clr) begin
                cnt_q <= '0;
            end else if (cnt_edge && cnt_q != 16'hFFFF) begin
                cnt_q <= cnt_q + 16'h1;
            end
        end
    end

    // Avalon-MM slave: every access sees exactly one wait cycle
    wire req = avs_read | avs_write;
    wire wr = avs_write & ~avs_waitrequest;
    wire [5:0] wa = avs_address[7:2];
    wire [31:0] wd = avs_writedata;
    wire in_pre = wa >= `DPS_A_PRE && wa < `DPS_A_TMR;
    wire in_tmr = wa >= `DPS_A_TMR && wa < `DPS_A_STAT;
    wire [2:0] pi = 3'(wa - `DPS_A_PRE);
    wire [2:0] ti = 3'(wa - `DPS_A_TMR);
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0;
        if (in_pre) begin
            rd_d = {16'h0, pre_q[pi]};
        end else if (in_tmr) begin
            rd_d = {16'h0, tmr_q[ti]};
        end else begin
            unique case (wa)
                `DPS_A_CTRL: rd_d = {23'h0, ctrl_q};
                `DPS_A_GAIN: rd_d = {22'h0, gain_q};
                `DPS_A_FILT: rd_d = {26'h0, filt_c_q};
                `DPS_A_ICNT: rd_d = {16'h0, thr_q};
                `DPS_A_SDIR: rd_d = {24'h0, sdir_q};
                `DPS_A_SRAMP: rd_d = {16'h0, sramp_q};
                `DPS_A_MAIN: rd_d = {16'h0, main_set_q};
                `DPS_A_STAT: rd_d = {8'h0, count_mid_q, draw_done_q, 3'(st_q), step_q,
                                     freq_cmd_q};
                `DPS_A_CNT: rd_d = {16'h0, cnt_q};
                default: rd_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_d;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '0;
            gain_q <= `DPS_GAIN_MAX;
            filt_c_q <= `DPS_FILT_RST;
            thr_q <= '0;
            sdir_q <= '0;
            sramp_q <= '0;
            main_set_q <= '0;
            {pre_q[0], pre_q[1], pre_q[2], pre_q[3], pre_q[4], pre_q[5], pre_q[6]} <= `DPS_PRE_RST;
            {tmr_q[0], tmr_q[1], tmr_q[2], tmr_q[3], tmr_q[4], tmr_q[5], tmr_q[6], tmr_q[7]}
                <= `DPS_TMR_RST;
        end else if (wr) begin
            if (in_pre) begin
                pre_q[pi] <= wd[15:0];
            end
            if (in_tmr) begin
                tmr_q[ti] <= wd[15:0];
            end
            unique case (wa)
                `DPS_A_CTRL: begin
                    ctrl_q <= wd[8:0];
                    if (wd[`DPS_F_PAT +: 3] > `DPS_PAT_DRAW) begin
                        ctrl_q[`DPS_F_PAT +: 3] <= pat; // R9
                    end
                end
                `DPS_A_GAIN: gain_q <= wd[15:0] > 16'(`DPS_GAIN_MAX) ? `DPS_GAIN_MAX : wd[9:0];
                `DPS_A_FILT: filt_c_q <= wd[15:0] > 16'(`DPS_FILT_MAX) ? `DPS_FILT_MAX : wd[5:0];
                `DPS_A_ICNT: thr_q <= wd[15:0] > `DPS_ICNT_MAX ? `DPS_ICNT_MAX : wd[15:0];
                `DPS_A_SDIR: sdir_q <= wd[7:0];
                `DPS_A_SRAMP: sramp_q <= wd[15:0];
                `DPS_A_MAIN: main_set_q <= wd[15:0]; // R5
                default: begin
                end
            endcase
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_neg_block: assert property (an_rev && !nbr |-> afreq == 16'h0000) // R2
        else $error("negative bias passed while reverse blocked");
    a_analog_dir: assert property (st_q == ST_RUN && is_norm && src && an_rev && nbr // R1
        |=> dir_rev_q) else $error("negative bias did not request reverse");
    a_gain_range: assert property (gain_q <= `DPS_GAIN_MAX) // R3
        else $error("meter gain above full scale");
    a_ud_clear: assert property (st_q == ST_IDLE && run_edge && !stop_any && !retain // R4
        |=> ud_q == 17'sh0) else $error("up/down offset kept at restart");
    a_filt_range: assert property (filt_c_q <= `DPS_FILT_MAX) // R7
        else $error("filter constant out of range");
    a_mid_count: assert property (!$past(rst) // R8
        |-> count_mid_q == ($past(cnt_q) >= $past(thr_q)))
        else $error("intermediate count output wrong");
    a_int_dir: assert property (st_q == ST_RUN && pat == `DPS_PAT_INT // R17
        |=> dir_rev_q == $past(int_dir)) else $error("step direction not applied");
    a_hold_done: assert property (st_q == ST_HOLD && !stop_any // R20
        |=> st_q == ST_HOLD && draw_done_q && freq_cmd_q == pre_q[1])
        else $error("drawing hold wrong");
    a_stop_idle: assert property (stop_any && st_q != ST_IDLE // R14
        |=> st_q == ST_IDLE ##1 freq_cmd_q == 16'h0000) else $error("stop not obeyed");
    a_single_end: assert property (st_q == ST_RUN && pat == `DPS_PAT_INT && tick && !stop_any
        && tcnt_q + 16'h1 >= tcur && end_stop |=> st_q == ST_IDLE) // R23
        else $error("single cycle did not stop");
endmodule
`default_nettype wire

// file: bench/dps_terms.sv
// Terminal-side model: momentary pins, select code and direction terminal.
// Assumes its tasks are called just after a rising clock edge.
`default_nettype none
module dps_terms (
    input wire logic clk,
    output logic run_in,
    output logic stop_in,
    output logic up_in,
    output logic trig_in,
    output logic count_in,
    output logic count_clr_in,
    output logic fwd_rev_in,
    output logic [2:0] speed_sel_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] mom_q;
    assign {count_clr_in, count_in, trig_in, up_in, stop_in, run_in} = mom_q;
    initial begin
        mom_q = 6'h00;
        fwd_rev_in = 1'h0;
        speed_sel_in = 3'h0;
    end
    // Pin k high for n cycles, then low as long, so each press is one clean edge
    task automatic pulse(input int k, input int n);
        mom_q[k] <= 1'h1;
        repeat (n) @(posedge clk);
        mom_q[k] <= 1'h0;
        repeat (n) @(posedge clk);
    endtask
    // Held past the debouncer so the new code settles before anyone looks
    task automatic select(input logic [2:0] code, input logic rev);
        speed_sel_in <= code;
        fwd_rev_in <= rev;
        repeat (230) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: bench/drive_speed_program_select_bench.sv
// Self-checking bench of the speed-program block: register bus and terminals.
// Assumes dps_cfg.svh on the include path and dps_pkg compiled first.
`include "dps_cfg.svh"
`default_nettype none
`define CHK(n, e, g) cmp(n, 32'(e), 32'(g))
module drive_speed_program_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dps_pkg::*;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, dir_rev_q, running_q;
    logic draw_done_q, count_mid_q, run_in, stop_in, up_in, trig_in, count_in;
    logic count_clr_in, fwd_rev_in;
    logic [2:0] speed_sel_in;
    logic [1:0] ramp_sel_in;
    logic [1:0] ramp_set_q;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] meter_output_q, analog_in;
    dps_freq_t freq_cmd_q;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int want;
    int pre[7] = '{1500, 2000, 2500, 3000, 3500, 4000, 50};
    dps_core #(.TICK_CYC(20)) uut (
        .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .run_in, .stop_in, .fault_in(1'h0), .estop_in(1'h0), .fwd_rev_in,
        .up_in, .down_in(1'h0), .trig_in, .count_in, .count_clr_in, .speed_sel_in,
        .ramp_sel_in, .analog_in, .freq_cmd_q, .dir_rev_q, .ramp_set_q,
        .running_q, .draw_done_q, .count_mid_q, .meter_output_q
    );
    dps_terms term (
        .clk, .run_in, .stop_in, .up_in, .trig_in, .count_in, .count_clr_in, .fwd_rev_in,
        .speed_sel_in
    );
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        avs_address <= {a, 2'h0};
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        `CHK(n, e, rd);
    endtask
    task automatic conclude();
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'h1;
        {avs_read, avs_write, avs_address, avs_writedata, ramp_sel_in, analog_in} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rchk("gain", `DPS_A_GAIN, 32'h3E8);
        rchk("filt", `DPS_A_FILT, 32'h14);
        rchk("ctrl", `DPS_A_CTRL, 32'h0);
        rchk("unmapped", 6'h3F, 32'h0);
        bus(1'h1, `DPS_A_GAIN, 32'h7FF);
        rchk("gain max", `DPS_A_GAIN, 32'h3E8);
        bus(1'h1, `DPS_A_FILT, 32'h3F);
        rchk("filt max", `DPS_A_FILT, 32'h32);
        bus(1'h1, `DPS_A_ICNT, 32'hFFFF);
        rchk("icnt max", `DPS_A_ICNT, 32'hFFDC);
        bus(1'h1, `DPS_A_CTRL, 32'h30);
        rchk("pattern 6", `DPS_A_CTRL, 32'h0);
        bus(1'h1, `DPS_A_MAIN, 32'h3E8);
        bus(1'h1, `DPS_A_GAIN, 32'h1F4);
        bus(1'h1, `DPS_A_CTRL, 32'h10);
        term.pulse(0, 4);
        for (int c = 0; c < 8; c++) begin
            ramp_sel_in <= 2'(7 - c);
            term.select(3'(c), 1'(c));
            want = (c == 0) ? 1000 : pre[c - 1];
            `CHK("ext speed", want, freq_cmd_q);
            `CHK("meter", want / 2, meter_output_q);
            `CHK("ext ramp", (7 - c) % 4, ramp_set_q);
            `CHK("ext dir", c % 2, dir_rev_q);
        end
        bus(1'h1, `DPS_A_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        `CHK("select off", 1000, freq_cmd_q);
        term.pulse(2, 4);
        `CHK("up coarse", 1010, freq_cmd_q);
        bus(1'h1, `DPS_A_CTRL, 32'h4);
        term.pulse(2, 4);
        `CHK("up fine", 1011, freq_cmd_q);
        term.pulse(1, 4);
        term.pulse(0, 4);
        `CHK("up dropped", 1000, freq_cmd_q);
        bus(1'h1, `DPS_A_CTRL, 32'h2);
        term.pulse(2, 4);
        term.pulse(1, 4);
        term.pulse(0, 4);
        `CHK("up kept", 1010, freq_cmd_q);
        term.pulse(1, 4);
        bus(1'h1, `DPS_A_CTRL, 32'h18);
        term.pulse(0, 4);
        `CHK("skip", 950, freq_cmd_q);
        term.select(3'h5, 1'h1);
        term.pulse(2, 4);
        `CHK("trav freq", 1000, freq_cmd_q);
        `CHK("trav dir", 0, dir_rev_q);
        term.pulse(1, 4);
        bus(1'h1, `DPS_A_TMR, 32'h0);
        bus(1'h1, `DPS_A_TMR + 6'h1, 32'h2);
        bus(1'h1, `DPS_A_SRAMP, 32'hC);
        bus(1'h1, `DPS_A_CTRL, 32'h20);
        term.pulse(0, 4);
        `CHK("step freq", 1500, freq_cmd_q);
        `CHK("step dir", 0, dir_rev_q);
        `CHK("step ramp", 3, ramp_set_q);
        repeat (60) @(posedge clk);
        `CHK("one cycle", 0, running_q);
        bus(1'h1, `DPS_A_CTRL, 32'h60);
        term.pulse(0, 4);
        repeat (60) @(posedge clk);
        `CHK("cycling", 1, running_q);
        term.pulse(1, 4);
        bus(1'h1, `DPS_A_TMR, 32'h1);
        bus(1'h1, `DPS_A_CTRL, 32'h28);
        term.pulse(0, 4);
        `CHK("draw wait", 1000, freq_cmd_q);
        term.pulse(3, 250);
        `CHK("draw hold", 2000, freq_cmd_q);
        `CHK("draw done", 1, draw_done_q);
        term.pulse(1, 4);
        `CHK("draw free", 0, draw_done_q);
        bus(1'h1, `DPS_A_ICNT, 32'h3);
        term.pulse(5, 4);
        repeat (2) term.pulse(4, 4);
        `CHK("below mid", 0, count_mid_q);
        term.pulse(4, 4);
        `CHK("mid", 1, count_mid_q);
        rchk("count", `DPS_A_CNT, 32'h3);
        bus(1'h1, `DPS_A_FILT, 32'h0);
        bus(1'h1, `DPS_A_CTRL, 32'h100);
        analog_in <= 16'hFF60;
        term.pulse(0, 4);
        repeat (200) @(posedge clk);
        `CHK("neg blocked", 0, freq_cmd_q);
        `CHK("neg forward", 0, dir_rev_q);
        bus(1'h1, `DPS_A_CTRL, 32'h101);
        repeat (12000) @(posedge clk);
        `CHK("pot freq", 160, freq_cmd_q);
        `CHK("pot reverse", 1, dir_rev_q);
        conclude();
    end
endmodule
`default_nettype wire
